/* rtl/ctb_pkg.sv */
// Constants shared by the transmit buffer payload store and its testbench.
// Assumes a 32-bit classic Wishbone slave with an 8-bit byte address.
package ctb_pkg;

  // Register map (byte addresses of aligned words; the data area holds eight)
  localparam logic [7:0] CTB_OFS_EIDH = 8'h00;
  localparam logic [7:0] CTB_OFS_EIDL = 8'h04;
  localparam logic [7:0] CTB_OFS_DLC = 8'h08;
  localparam logic [7:0] CTB_OFS_DATA = 8'h20;
  localparam logic [7:0] CTB_BUF_STRIDE = 8'h40;
  localparam logic [7:0] CTB_OFS_CTRL = 8'hC0;
  localparam logic [7:0] CTB_OFS_STAT = 8'hC4;

  // Field positions
  localparam int CTB_RTR_BIT = 6;
  localparam int CTB_HDR_EXT_BIT = 4;
  localparam int CTB_CTRL_SEND_LSB = 8;
  localparam int CTB_STAT_BUSY_BIT = 8;

  // Length code limits
  localparam logic [3:0] CTB_DLC_MAX = 4'h8;

  // Reset values of control state
  localparam logic [2:0] CTB_EXT_RESET = 3'h0;
  localparam logic [2:0] CTB_PEND_RESET = 3'h0;

  // Frame assembly states
  typedef enum logic [4:0] {
    CTB_IDLE = 5'h01,
    CTB_HDR = 5'h02,
    CTB_EIDH = 5'h04,
    CTB_EIDL = 5'h08,
    CTB_DATA = 5'h10
  } ctb_state_t;

endpackage : ctb_pkg

/* rtl/ctb_stream_if.sv */
// Valid/ready stream into and out of the frame assembler's FIFO.
// Assumes both ends sit on the same clock.
`timescale 1ns/100ps
`default_nettype none
interface ctb_stream_if #(parameter int WIDTH = 9);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : ctb_stream_if
`default_nettype wire

/* rtl/ctb_fifo.sv */
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and an already synchronised active-low reset.
`timescale 1ns/100ps
`default_nettype none
module ctb_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Fill and drain sides
  ctb_stream_if.snk wr,
  ctb_stream_if.src rd
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wptr;
  logic [AW-1:0] rptr;
  logic [AW:0] count;
  logic [AW-1:0] next_wptr;
  logic [AW-1:0] next_rptr;
  logic [AW:0] next_count;
  logic do_wr;
  logic do_rd;

  assign wr.ready = (count < (AW+1)'(DEPTH));
  assign rd.valid = (count != '0);
  assign rd.data = mem[rptr];

  always_comb begin
    do_wr = wr.valid & wr.ready;
    do_rd = rd.valid & rd.ready;
    next_wptr = wptr;
    next_rptr = rptr;
    if (do_wr) begin
      next_wptr = (wptr == AW'(DEPTH - 1)) ? '0 : wptr + 1'b1;
    end
    if (do_rd) begin
      next_rptr = (rptr == AW'(DEPTH - 1)) ? '0 : rptr + 1'b1;
    end
    next_count = count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wptr <= '0;
      rptr <= '0;
      count <= '0;
    end else begin
      wptr <= next_wptr;
      rptr <= next_rptr;
      count <= next_count;
    end
  end

  // Storage holds no reset, so it maps onto plain RAM
  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem[wptr] <= wr.data;
    end
  end

  fifo_bound_a: assert property (@(posedge clk) disable iff (!rst_n)
    count <= (AW+1)'(DEPTH))
    else $error("FIFO count above depth");

endmodule : ctb_fifo
`default_nettype wire

/* rtl/ctb_payload.sv */
// Transmit buffer payload store: identifier bytes, data bytes and length
// code of three buffers, with a frame assembler feeding the transmit engine.
// Assumes a classic Wishbone master and an engine on the same clock.
`timescale 1ns/100ps
`default_nettype none
module ctb_payload #(
  parameter int NBUF = 3,
  parameter int NDATA = 8,
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // Wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [3:0] WB_SEL_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // Frame content stream to the transmit engine
  output logic [7:0] TX_DATA,
  output logic TX_LAST,
  output logic TX_VALID,
  input wire logic TX_READY
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Storage
  logic [7:0] eid_high [NBUF];
  logic [7:0] eid_low [NBUF];
  logic remote_request_select [NBUF];
  logic [3:0] payload_length_code [NBUF];
  logic [7:0] payload [NBUF][NDATA];
  logic [2:0] extended_ident_enable;
  logic [2:0] pending;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  logic [1:0] sel_buf;
  logic [5:0] sel_ofs;
  logic req;
  logic wr_hit;
  logic buf_ok;
  logic [2:0] send_set;
  logic [2:0] taken;
  logic busy;
  logic next_ack;
  logic [31:0] next_rdata;
  logic [2:0] next_ext;
  logic [2:0] next_pending;

  assign sel_buf = WB_ADR_I[7:6];
  assign sel_ofs = WB_ADR_I[5:0];
  assign buf_ok = (int'(sel_buf) < NBUF);
  assign req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  assign wr_hit = req & WB_WE_I & WB_SEL_I[0];

  always_comb begin
    next_ack = req;
    next_rdata = 32'h00000000;
    if (req && !WB_WE_I && buf_ok) begin
      if ({2'b00, sel_ofs} == ctb_pkg::CTB_OFS_EIDH) begin
        next_rdata[7:0] = eid_high[sel_buf];
      end else if ({2'b00, sel_ofs} == ctb_pkg::CTB_OFS_EIDL) begin
        next_rdata[7:0] = eid_low[sel_buf];
      end else if ({2'b00, sel_ofs} == ctb_pkg::CTB_OFS_DLC) begin
        next_rdata[ctb_pkg::CTB_RTR_BIT] = remote_request_select[sel_buf];
        next_rdata[3:0] = payload_length_code[sel_buf];
      end else if ({2'b00, sel_ofs} >= ctb_pkg::CTB_OFS_DATA) begin
        next_rdata[7:0] = payload[sel_buf][sel_ofs[4:2]];
      end
    end else if (req && !WB_WE_I) begin
      if (WB_ADR_I == ctb_pkg::CTB_OFS_CTRL) begin
        next_rdata[2:0] = extended_ident_enable;
      end else if (WB_ADR_I == ctb_pkg::CTB_OFS_STAT) begin
        next_rdata[2:0] = pending;
        next_rdata[ctb_pkg::CTB_STAT_BUSY_BIT] = busy;
      end
    end
  end

  always_comb begin
    send_set = 3'h0;
    next_ext = extended_ident_enable;
    if (wr_hit && WB_ADR_I == ctb_pkg::CTB_OFS_CTRL) begin
      next_ext = WB_DAT_I[2:0];
    end
    if (req && WB_WE_I && WB_SEL_I[1] && WB_ADR_I == ctb_pkg::CTB_OFS_CTRL)
    begin
      send_set = WB_DAT_I[ctb_pkg::CTB_CTRL_SEND_LSB +: 3];
    end
    // A request written while its bit is being taken is kept
    next_pending = (pending & ~taken) | send_set;
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h00000000;
      extended_ident_enable <= ctb_pkg::CTB_EXT_RESET;
      pending <= ctb_pkg::CTB_PEND_RESET;
    end else begin
      WB_ACK_O <= next_ack;
      WB_DAT_O <= next_rdata;
      extended_ident_enable <= next_ext;
      pending <= next_pending;
    end
  end

  // Payload registers carry no reset: their power-on content is undefined
  always_ff @(posedge CLK) begin
    if (wr_hit && buf_ok) begin
      if ({2'b00, sel_ofs} == ctb_pkg::CTB_OFS_EIDH) begin
        eid_high[sel_buf] <= WB_DAT_I[7:0];
      end else if ({2'b00, sel_ofs} == ctb_pkg::CTB_OFS_EIDL) begin
        eid_low[sel_buf] <= WB_DAT_I[7:0];
      end else if ({2'b00, sel_ofs} == ctb_pkg::CTB_OFS_DLC) begin
        remote_request_select[sel_buf] <= WB_DAT_I[ctb_pkg::CTB_RTR_BIT];
        payload_length_code[sel_buf] <= WB_DAT_I[3:0];
      end else if ({2'b00, sel_ofs} >= ctb_pkg::CTB_OFS_DATA) begin
        payload[sel_buf][sel_ofs[4:2]] <= WB_DAT_I[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame assembler
  // Software must not rewrite a buffer while it is being sent: the bytes
  // are read live, trading a snapshot copy for area.
  ctb_stream_if #(.WIDTH(9)) fill ();
  ctb_stream_if #(.WIDTH(9)) drain ();

  ctb_pkg::ctb_state_t state;
  ctb_pkg::ctb_state_t next_state;
  logic [1:0] cur;
  logic [1:0] next_cur;
  logic [2:0] idx;
  logic [2:0] next_idx;
  logic [3:0] cnt;
  logic no_data;
  logic data_last;

  assign busy = (state != ctb_pkg::CTB_IDLE);

  always_comb begin
    // Reserved codes above eight still send eight bytes
    cnt = (payload_length_code[cur] > ctb_pkg::CTB_DLC_MAX) ?
          ctb_pkg::CTB_DLC_MAX : payload_length_code[cur];
    no_data = remote_request_select[cur] || (cnt == 4'h0);
    data_last = ({1'b0, idx} + 4'h1 == cnt);
  end

  always_comb begin
    next_state = state;
    next_cur = cur;
    next_idx = idx;
    taken = 3'h0;
    fill.valid = 1'b0;
    fill.data = 9'h000;
    unique case (state)
      ctb_pkg::CTB_IDLE: begin
        next_idx = 3'h0;
        if (pending[0]) begin
          taken = 3'h1;
          next_cur = 2'h0;
          next_state = ctb_pkg::CTB_HDR;
        end else if (pending[1]) begin
          taken = 3'h2;
          next_cur = 2'h1;
          next_state = ctb_pkg::CTB_HDR;
        end else if (pending[2]) begin
          taken = 3'h4;
          next_cur = 2'h2;
          next_state = ctb_pkg::CTB_HDR;
        end
      end
      ctb_pkg::CTB_HDR: begin
        fill.valid = 1'b1;
        fill.data[3:0] = payload_length_code[cur];
        fill.data[ctb_pkg::CTB_HDR_EXT_BIT] = extended_ident_enable[cur];
        fill.data[ctb_pkg::CTB_RTR_BIT] = remote_request_select[cur];
        fill.data[8] = !extended_ident_enable[cur] && no_data;
        if (fill.ready) begin
          if (extended_ident_enable[cur]) begin
            next_state = ctb_pkg::CTB_EIDH;
          end else if (no_data) begin
            next_state = ctb_pkg::CTB_IDLE;
          end else begin
            next_state = ctb_pkg::CTB_DATA;
          end
        end
      end
      ctb_pkg::CTB_EIDH: begin
        fill.valid = 1'b1;
        fill.data = {1'b0, eid_high[cur]};
        if (fill.ready) begin
          next_state = ctb_pkg::CTB_EIDL;
        end
      end
      ctb_pkg::CTB_EIDL: begin
        fill.valid = 1'b1;
        fill.data = {no_data, eid_low[cur]};
        if (fill.ready) begin
          next_state = no_data ? ctb_pkg::CTB_IDLE : ctb_pkg::CTB_DATA;
        end
      end
      ctb_pkg::CTB_DATA: begin
        fill.valid = 1'b1;
        fill.data = {data_last, payload[cur][idx]};
        if (fill.ready) begin
          next_idx = idx + 3'h1;
          if (data_last) begin
            next_state = ctb_pkg::CTB_IDLE;
          end
        end
      end
      default: begin
        next_state = ctb_pkg::CTB_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      state <= ctb_pkg::CTB_IDLE;
      cur <= 2'h0;
      idx <= 3'h0;
    end else begin
      state <= next_state;
      cur <= next_cur;
      idx <= next_idx;
    end
  end

  ctb_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(CLK),
    .rst_n(rst_n),
    .wr(fill),
    .rd(drain)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Output stage keeps every output port on a flip-flop
  logic next_tx_valid;
  logic [8:0] next_tx_word;

  always_comb begin
    drain.ready = !TX_VALID || TX_READY;
    next_tx_valid = TX_VALID;
    next_tx_word = {TX_LAST, TX_DATA};
    if (drain.ready) begin
      next_tx_valid = drain.valid;
      if (drain.valid) begin
        next_tx_word = drain.data;
      end
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      TX_VALID <= 1'b0;
      TX_LAST <= 1'b0;
      TX_DATA <= 8'h00;
    end else begin
      TX_VALID <= next_tx_valid;
      TX_LAST <= next_tx_word[8];
      TX_DATA <= next_tx_word[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  eid_high_sent_a: assert property (@(posedge CLK) disable iff (!rst_n)
    state == ctb_pkg::CTB_EIDH |-> fill.data[7:0] == eid_high[cur])
    else $error("High identifier byte mismatch");

  eid_low_sent_a: assert property (@(posedge CLK) disable iff (!rst_n)
    state == ctb_pkg::CTB_EIDH && fill.ready
    |=> state == ctb_pkg::CTB_EIDL && fill.data[7:0] == eid_low[cur])
    else $error("Low identifier byte not next");

  buffer_index_a: assert property (@(posedge CLK) disable iff (!rst_n)
    state != ctb_pkg::CTB_IDLE |-> int'(cur) < NBUF)
    else $error("Buffer index out of range");

  data_order_a: assert property (@(posedge CLK) disable iff (!rst_n)
    state == ctb_pkg::CTB_DATA && fill.ready && !data_last
    |=> state == ctb_pkg::CTB_DATA && idx == $past(idx) + 3'h1)
    else $error("Data bytes out of order");

  data_count_a: assert property (@(posedge CLK) disable iff (!rst_n)
    state == ctb_pkg::CTB_DATA |-> {1'b0, idx} < cnt && cnt <= 4'h8)
    else $error("Data byte beyond length code");

  length_read_a: assert property (@(posedge CLK) disable iff (!rst_n)
    req && !WB_WE_I && buf_ok && {2'b00, sel_ofs} == ctb_pkg::CTB_OFS_DLC
    |=> WB_ACK_O && WB_DAT_O[7] == 1'b0 && WB_DAT_O[5:4] == 2'b00)
    else $error("Unimplemented length bits not zero");

  remote_skip_a: assert property (@(posedge CLK) disable iff (!rst_n)
    state == ctb_pkg::CTB_EIDL && remote_request_select[cur] && fill.ready
    |=> state == ctb_pkg::CTB_IDLE)
    else $error("Remote frame carried data");

  std_skip_a: assert property (@(posedge CLK) disable iff (!rst_n)
    state == ctb_pkg::CTB_HDR && !extended_ident_enable[cur] && fill.ready
    |=> state != ctb_pkg::CTB_EIDH)
    else $error("Standard frame sent extended bytes");

endmodule : ctb_payload
`default_nettype wire

/* test/ctb_engine_model.sv */
// Transmit engine stand-in: accepts frame bytes and logs them.
// Assumes the payload store's stream on the same clock.
`timescale 1ns/100ps
`default_nettype none
module ctb_engine_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Stall pattern select
  input wire logic slow,
  // Stream from the store
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  input wire logic tx_valid,
  output logic tx_ready
);
  // Received bytes, {last, data}; the bench reads and empties this
  logic [8:0] got[$];
  logic tog;

  ////////////////////////////////////////////////////////////////////////
  // Slow mode stalls every other cycle to exercise holding of the byte
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_ready <= 1'b0;
      tog <= 1'b0;
    end else begin
      if (tx_valid && tx_ready) got.push_back({tx_last, tx_data});
      tog <= ~tog;
      tx_ready <= slow ? tog : 1'b1;
    end
  end
endmodule : ctb_engine_model
`default_nettype wire

/* test/testbench.sv */
// Self-checking bench: Wishbone register access and frame streaming.
// Assumes the engine model as the far side of the stream.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clk, rst_n, cyc, stb, we, slow, ack, tx_last, tx_valid, tx_ready;
  logic [7:0] adr, tx_data;
  logic [31:0] dat, q, dat_o;
  logic [3:0] sel;
  logic [7:0] eidh[3], eidl[3];
  logic [8:0] exq[$];
  int error_cnt = 0;
  int n_compared = 0;

  ctb_payload #(.NBUF(3), .NDATA(8), .FIFO_DEPTH(8)) DUT (
    .CLK(clk), .RESET_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_DAT_I(dat), .WB_SEL_I(sel),
    .WB_DAT_O(dat_o), .WB_ACK_O(ack), .TX_DATA(tx_data),
    .TX_LAST(tx_last), .TX_VALID(tx_valid), .TX_READY(tx_ready)
  );
  ctb_engine_model eng (
    .clk(clk), .rst_n(rst_n), .slow(slow), .tx_data(tx_data),
    .tx_last(tx_last), .tx_valid(tx_valid), .tx_ready(tx_ready)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] pat(int n, int m);
    return 8'(n * 16 + m) ^ 8'hA5;
  endfunction : pat

  task automatic final_report();
    $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] g, input logic [31:0] e,
                     input string m);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk

  // Classic single cycle; no fixed latency is assumed
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hF;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = dat_o;
    if (n >= 20) begin
      error_cnt++;
      $display("MISMATCH at %0t: no ack", $time);
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask : wb

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(q, e, "register read");
  endtask : rc

  task automatic add_frame(int n, logic ext, logic rtr, logic [3:0] code);
    exq.push_back({1'b0, 1'b0, rtr, 1'b0, ext, code});
    if (ext) begin
      exq.push_back({1'b0, eidh[n]});
      exq.push_back({1'b0, eidl[n]});
    end
    if (!rtr) for (int m = 0; m < code; m++) exq.push_back({1'b0, pat(n, m)});
    exq[exq.size() - 1][8] = 1'b1;
  endtask : add_frame

  // Start the sends and compare the whole byte stream with the model's log
  task automatic run(logic [2:0] ext, logic [2:0] go);
    int n;
    wb(1'b1, ctb_pkg::CTB_OFS_CTRL, {21'h0, go, 5'h0, ext});
    n = 0;
    while (eng.got.size() < exq.size() && n < 400) begin
      @(posedge clk);
      n++;
    end
    repeat (4) @(posedge clk);
    chk(32'(eng.got.size()), 32'(exq.size()), "frame length");
    foreach (exq[i]) if (i < eng.got.size()) chk(eng.got[i], exq[i], "byte");
    eng.got.delete();
    exq.delete();
  endtask : run

  ////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] b;
    rst_n <= 1'b0;
    {cyc, stb, we, slow, adr, dat, sel} <= '0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rc(ctb_pkg::CTB_OFS_STAT, 32'h0);
    for (int n = 0; n < 3; n++) begin
      b = 8'(n * 64);
      eidh[n] = 8'hC3 ^ 8'(n);
      eidl[n] = 8'h3C + 8'(n);
      wb(1'b1, b + ctb_pkg::CTB_OFS_EIDH, {24'hFFFFFF, eidh[n]});
      wb(1'b1, b + ctb_pkg::CTB_OFS_EIDL, {24'hFFFFFF, eidl[n]});
      wb(1'b1, b + ctb_pkg::CTB_OFS_DLC, 32'hFFFFFFF8);
      for (int m = 0; m < 8; m++) begin
        wb(1'b1, b + ctb_pkg::CTB_OFS_DATA + 8'(4 * m), {24'h0, pat(n, m)});
      end
    end
    for (int n = 0; n < 3; n++) begin
      b = 8'(n * 64);
      rc(b + ctb_pkg::CTB_OFS_EIDH, {24'h0, eidh[n]});
      rc(b + ctb_pkg::CTB_OFS_EIDL, {24'h0, eidl[n]});
      rc(b + ctb_pkg::CTB_OFS_DLC, 32'h48);
      for (int m = 0; m < 8; m++) begin
        rc(b + ctb_pkg::CTB_OFS_DATA + 8'(4 * m),
           {24'h0, pat(n, m)});
      end
    end
    wb(1'b1, 8'hD0, 32'hFFFFFFFF);
    rc(8'hD0, 32'h0);
    $display("test registers done");
    // Every legal length, alternating prompt and stalling engine
    for (int c = 0; c <= 8; c++) begin
      slow <= c[0];
      wb(1'b1, ctb_pkg::CTB_OFS_DLC, {28'h0, 4'(c)});
      add_frame(0, 1'b0, 1'b0, 4'(c));
      run(3'h0, 3'h1);
    end
    $display("test lengths done");
    // Three sends at once: plain, remote, extended
    slow <= 1'b1;
    wb(1'b1, ctb_pkg::CTB_OFS_DLC, 32'h01);
    wb(1'b1, 8'h40 + ctb_pkg::CTB_OFS_DLC, 32'h43);
    wb(1'b1, 8'h80 + ctb_pkg::CTB_OFS_DLC, 32'h02);
    add_frame(0, 1'b0, 1'b0, 4'h1);
    add_frame(1, 1'b0, 1'b1, 4'h3);
    add_frame(2, 1'b1, 1'b0, 4'h2);
    run(3'h4, 3'h7);
    rc(ctb_pkg::CTB_OFS_CTRL, 32'h4);
    rc(ctb_pkg::CTB_OFS_STAT, 32'h0);
    $display("test mixed frames done");
    final_report();
  end

  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    final_report();
  end
endmodule : testbench
`default_nettype wire
